// ### ebc_bus_cycle.sv
// external bus cycle sequencer with register slave and link-clock timing core
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - demux cycle 4/6 units plus wait terms
// - mux cycle 6/8 units plus wait terms
// - software picks latch length and two waitstates
// - ready input stretches cycle when enabled
// - async ready synchronised, at least one waitstate
// - ready high adds waitstate, low ends cycle
// - mux cycle ends with mux then tristate wait
// - first sample point follows previous tail, waits
// - reference clock period is two half units
module ebc_bus_cycle (
  // system clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // link clock
  input wire logic linkClk,
  // external bus pins
  input wire logic readyN,
  output logic reference_clock_output,
  output logic addrLatch,
  output logic rdStrobeN,
  output logic wrStrobeN,
  output logic busActive
);
  import ebc_pkg::*;

  // ----------------------------------------------------------------------
  // system-side state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [EBC_CFG_W-1:0] cfg;
    logic [EBC_CFG_W-1:0] cfgReq;
    logic wrReq;
    logic busy;
    logic reqTog;
    logic doneSeen;
    logic [EBC_LEN_W-1:0] lastLen;
    logic lastRdyExt;
    logic [31:0] rdData;
    logic rdValid;
  } ebc_sys_s;

  // link-side state
  typedef struct packed {
    ebc_state_e state;
    logic [5:0] cnt;
    logic reqSeen;
    logic doneTog;
    logic [EBC_LEN_W-1:0] len;
    logic rdyExt;
    logic firstWait;
    logic refClk;
    logic latch;
    logic strobe;
    logic active;
    logic wr;
    logic [5:0] tail;
  } ebc_link_s;

  ebc_sys_s sys_ff;
  ebc_sys_s nxt_sys;
  ebc_link_s link_ff;
  ebc_link_s nxt_link;

  logic linkRst;
  logic reqSync;
  logic doneSync;
  logic readyAsyncN;
  logic waitReq;
  logic [31:0] rdMux;

  // ----------------------------------------------------------------------
  // crossings
  // ----------------------------------------------------------------------
  ebc_sync2 u_rst_sync (
    .clk(linkClk),
    .rst(1'b0),
    .din(sys_rst),
    .dout(linkRst)
  );

  ebc_sync2 u_req_sync (
    .clk(linkClk),
    .rst(linkRst),
    .din(sys_ff.reqTog),
    .dout(reqSync)
  );

  ebc_sync2 u_done_sync (
    .clk(clk),
    .rst(sys_rst),
    .din(link_ff.doneTog),
    .dout(doneSync)
  );

  // async ready path: extra synchronisation stage
  ebc_pin_sync #(
    .RST_VAL(1'b1)
  ) u_ready_sync (
    .clk(linkClk),
    .rst(linkRst),
    .pin(readyN),
    .level(readyAsyncN)
  );

  // ----------------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------------
  always_comb
  begin
    rdMux = 32'h0000_0000;
    unique case (avs_address)
      EBC_CFG_OFS:
      begin
        rdMux[EBC_CFG_W-1:0] = sys_ff.cfg;
      end
      EBC_STAT_OFS:
      begin
        rdMux[EBC_STAT_BUSY_BIT] = sys_ff.busy;
        rdMux[EBC_STAT_RDYX_BIT] = sys_ff.lastRdyExt;
        rdMux[EBC_STAT_WR_BIT] = sys_ff.wrReq;
        rdMux[EBC_STAT_LEN_LSB +: EBC_LEN_W] = sys_ff.lastLen;
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // reads stall one cycle for registered data; a start while busy stalls
  always_comb
  begin
    waitReq = 1'b0;
    if (avs_read)
    begin
      waitReq = !sys_ff.rdValid;
    end
    else if (avs_write && avs_address == EBC_CMD_OFS && sys_ff.busy)
    begin
      waitReq = 1'b1;
    end
  end

  assign avs_waitrequest = waitReq;
  assign avs_readdata = sys_ff.rdData;

  // ----------------------------------------------------------------------
  // system-side next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_sys = sys_ff;
    nxt_sys.rdValid = 1'b0;
    if (avs_read && !sys_ff.rdValid)
    begin
      nxt_sys.rdValid = 1'b1;
      nxt_sys.rdData = rdMux;
    end
    // finished cycle: length word is stable on the link side by now
    if (doneSync != sys_ff.doneSeen)
    begin
      nxt_sys.doneSeen = doneSync;
      nxt_sys.busy = 1'b0;
      nxt_sys.lastLen = link_ff.len;
      nxt_sys.lastRdyExt = link_ff.rdyExt;
    end
    if (avs_write && !waitReq)
    begin
      unique case (avs_address)
        EBC_CFG_OFS:
        begin
          // latch length and both waitstate kinds are software choices
          if (avs_byteenable[0])
          begin
            nxt_sys.cfg[7:0] = avs_writedata[7:0];
          end
          if (avs_byteenable[1])
          begin
            nxt_sys.cfg[EBC_CFG_W-1:8] = avs_writedata[EBC_CFG_W-1:8];
          end
        end
        EBC_CMD_OFS:
        begin
          if (avs_byteenable[0] && avs_writedata[EBC_CMD_START_BIT])
          begin
            nxt_sys.cfgReq = sys_ff.cfg;
            nxt_sys.wrReq = avs_writedata[EBC_CMD_WRITE_BIT];
            nxt_sys.busy = 1'b1;
            nxt_sys.reqTog = !sys_ff.reqTog;
          end
        end
        default: nxt_sys.busy = nxt_sys.busy;
      endcase
    end
    if (sys_rst)
    begin
      nxt_sys = '0;
      nxt_sys.cfg = EBC_CFG_RST;
    end
  end

  always_ff @(posedge clk)
  begin
    sys_ff <= nxt_sys;
  end

  // ----------------------------------------------------------------------
  // link-side sequencer, one link clock period per half_clock_unit
  // ----------------------------------------------------------------------
  logic [3:0] cfgWait;
  logic cfgTri;
  logic cfgExt;
  logic cfgMux;
  logic cfgRdyEn;
  logic cfgAsync;
  logic [5:0] waitTcl;
  logic [5:0] tailTcl;
  logic readyNow;
  logic riseNext;

  assign cfgWait = sys_ff.cfgReq[EBC_CFG_WAIT_LSB +: 4];
  assign cfgTri = sys_ff.cfgReq[EBC_CFG_TRI_BIT];
  assign cfgExt = sys_ff.cfgReq[EBC_CFG_EXT_BIT];
  assign cfgMux = sys_ff.cfgReq[EBC_CFG_MUX_BIT];
  assign cfgRdyEn = sys_ff.cfgReq[EBC_CFG_RDYEN_BIT];
  assign cfgAsync = sys_ff.cfgReq[EBC_CFG_ASYNC_BIT];

  // each decrement of the wait field adds one two-unit waitstate
  assign waitTcl = 6'((EBC_WAIT_MAX - cfgWait) * 2);
  // mux wait (mux mode only) then optional tristate wait close the cycle
  assign tailTcl = (cfgMux ? EBC_MUX_WAIT_TCL : 6'h00) + (cfgTri ? 6'h00 : EBC_TRI_WAIT_TCL);
  // sync mode samples the pin directly, async mode the synchronised level
  assign readyNow = cfgAsync ? !readyAsyncN : !readyN;
  // the next edge raises the reference clock: ready sampling point
  assign riseNext = !link_ff.refClk;

  always_comb
  begin
    nxt_link = link_ff;
    // toggle every unit: period of two half_clock_unit
    nxt_link.refClk = !link_ff.refClk;
    if (link_ff.state != EBC_IDLE && link_ff.len != EBC_LEN_MAX)
    begin
      nxt_link.len = link_ff.len + 8'h01;
    end
    unique case (link_ff.state)
      EBC_IDLE:
      begin
        // start aligned so every two-unit step ends on a reference clock falling edge
        if (reqSync != link_ff.reqSeen && link_ff.refClk)
        begin
          nxt_link.reqSeen = reqSync;
          nxt_link.state = EBC_LATCH;
          nxt_link.wr = sys_ff.wrReq;
          nxt_link.len = 8'h01;
          nxt_link.rdyExt = 1'b0;
          nxt_link.active = 1'b1;
          nxt_link.latch = 1'b1;
          nxt_link.tail = tailTcl;
          // normal or extended latch phase
          nxt_link.cnt = (cfgExt ? EBC_LATCH_EXT_TCL : EBC_LATCH_NORM_TCL) - 6'h01;
        end
      end
      EBC_LATCH:
      begin
        nxt_link.cnt = link_ff.cnt - 6'h01;
        if (link_ff.cnt == 6'h00)
        begin
          nxt_link.latch = 1'b0;
          nxt_link.strobe = 1'b1;
          nxt_link.state = EBC_CMD;
          // command phase plus cycle waitstates
          nxt_link.cnt = EBC_CMD_BASE_TCL + waitTcl - 6'h01;
        end
      end
      EBC_CMD:
      begin
        nxt_link.cnt = link_ff.cnt - 6'h01;
        if (link_ff.cnt == 6'h00)
        begin
          if (cfgRdyEn)
          begin
            // first sampling point sits after the previous tail, latch and waits
            nxt_link.state = EBC_RDY;
            nxt_link.firstWait = cfgAsync;
            nxt_link.cnt = 6'h00;
          end
          else
          begin
            nxt_link.strobe = 1'b0;
            nxt_link.state = EBC_TAIL;
            nxt_link.cnt = link_ff.tail;
          end
        end
      end
      EBC_RDY:
      begin
        // the external circuit decides the length through ready
        nxt_link.cnt = (link_ff.cnt == 6'h00) ? 6'h00 : link_ff.cnt - 6'h01;
        if (link_ff.cnt == 6'h00 && riseNext)
        begin
          // async mode always spends one waitstate in synchronisation
          if (link_ff.firstWait || readyNow == 1'b0)
          begin
            // ready high at the sample point: one more waitstate
            nxt_link.firstWait = 1'b0;
            nxt_link.rdyExt = 1'b1;
            nxt_link.cnt = EBC_UNIT_TCL - 6'h01;
          end
          else
          begin
            // ready low terminates the running cycle
            nxt_link.strobe = 1'b0;
            nxt_link.state = EBC_TAIL;
            nxt_link.cnt = link_ff.tail;
          end
        end
      end
      EBC_TAIL:
      begin
        nxt_link.cnt = link_ff.cnt - 6'h01;
      end
      default: nxt_link.state = EBC_IDLE;
    endcase
    // cycle closes when its tail runs out; with no tail it closes with the strobe
    if (nxt_link.state == EBC_TAIL && nxt_link.cnt == 6'h00)
    begin
      nxt_link.len = link_ff.len;
      nxt_link.active = 1'b0;
      nxt_link.state = EBC_IDLE;
      nxt_link.doneTog = !link_ff.doneTog;
    end
    if (linkRst)
    begin
      nxt_link = '0;
      nxt_link.state = EBC_IDLE;
    end
  end

  always_ff @(posedge linkClk)
  begin
    link_ff <= nxt_link;
  end

  // ----------------------------------------------------------------------
  // pin outputs, all from flops
  // ----------------------------------------------------------------------
  assign reference_clock_output = link_ff.refClk;
  assign addrLatch = link_ff.latch;
  assign rdStrobeN = !(link_ff.strobe && !link_ff.wr);
  assign wrStrobeN = !(link_ff.strobe && link_ff.wr);
  assign busActive = link_ff.active;

endmodule : ebc_bus_cycle
`default_nettype wire

// ### ebc_pkg.sv
// shared constants for the external bus cycle sequencer
package ebc_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------------
  localparam logic [3:0] EBC_CFG_OFS = 4'h0;
  localparam logic [3:0] EBC_CMD_OFS = 4'h4;
  localparam logic [3:0] EBC_STAT_OFS = 4'h8;

  // ----------------------------------------------------------------------
  // bus_config_regs field positions
  // ----------------------------------------------------------------------
  localparam int EBC_CFG_WAIT_LSB = 0;
  localparam int EBC_CFG_TRI_BIT = 4;
  localparam int EBC_CFG_EXT_BIT = 5;
  localparam int EBC_CFG_MUX_BIT = 6;
  localparam int EBC_CFG_RDYEN_BIT = 7;
  localparam int EBC_CFG_ASYNC_BIT = 8;
  localparam int EBC_CFG_W = 9;
  localparam logic [EBC_CFG_W-1:0] EBC_CFG_RST = 9'h000;

  // command and status fields
  localparam int EBC_CMD_START_BIT = 0;
  localparam int EBC_CMD_WRITE_BIT = 1;
  localparam int EBC_STAT_BUSY_BIT = 0;
  localparam int EBC_STAT_RDYX_BIT = 1;
  localparam int EBC_STAT_WR_BIT = 2;
  localparam int EBC_STAT_LEN_LSB = 8;
  localparam int EBC_LEN_W = 8;

  // ----------------------------------------------------------------------
  // cycle timing, all counts in half_clock_unit (one link clock period)
  // ----------------------------------------------------------------------
  localparam logic [5:0] EBC_LATCH_NORM_TCL = 6'h02;
  localparam logic [5:0] EBC_LATCH_EXT_TCL = 6'h04;
  localparam logic [5:0] EBC_CMD_BASE_TCL = 6'h02;
  localparam logic [3:0] EBC_WAIT_MAX = 4'hf;
  localparam logic [5:0] EBC_UNIT_TCL = 6'h02;
  localparam logic [5:0] EBC_MUX_WAIT_TCL = 6'h02;
  localparam logic [5:0] EBC_TRI_WAIT_TCL = 6'h02;
  localparam logic [EBC_LEN_W-1:0] EBC_LEN_MAX = 8'hff;

  // sequencer states
  typedef enum logic [4:0] {
    EBC_IDLE = 5'b00001,
    EBC_LATCH = 5'b00010,
    EBC_CMD = 5'b00100,
    EBC_RDY = 5'b01000,
    EBC_TAIL = 5'b10000
  } ebc_state_e;

endpackage : ebc_pkg

// ### ebc_sync2.sv
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module ebc_sync2 (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // level in and out
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic meta;
    logic stable;
  } ebc_sync2_s;

  ebc_sync2_s q_ff;
  ebc_sync2_s nxt_q;

  always_comb
  begin
    nxt_q.meta = din;
    nxt_q.stable = q_ff.meta;
    if (rst)
    begin
      nxt_q = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    q_ff <= nxt_q;
  end

  assign dout = q_ff.stable;
endmodule : ebc_sync2
`default_nettype wire

// ### ebc_pin_sync.sv
// three-flop pin synchroniser, output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ebc_pin_sync #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pin in, filtered level out
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } ebc_pin_sync_s;

  ebc_pin_sync_s q_ff;
  ebc_pin_sync_s nxt_q;

  always_comb
  begin
    nxt_q.s1 = pin;
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
    nxt_q.lvl = (q_ff.s2 == q_ff.s3) ? q_ff.s3 : q_ff.lvl;
    if (rst)
    begin
      nxt_q = {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end
  end

  always_ff @(posedge clk)
  begin
    q_ff <= nxt_q;
  end

  assign level = q_ff.lvl;
endmodule : ebc_pin_sync
`default_nettype wire

// ### ebc_bus_cycle_chk.sv
// concurrent checks on the bus cycle sequencer ports
`timescale 1ns/1ps
`default_nettype none
module ebc_bus_cycle_chk (
  // clocks and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic linkClk,
  // register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // external bus pins
  input wire logic reference_clock_output,
  input wire logic addrLatch,
  input wire logic rdStrobeN,
  input wire logic wrStrobeN,
  input wire logic busActive
);
  // ----------------------------------------------------------------------
  // link side
  // ----------------------------------------------------------------------
  property p_refToggle;
    @(posedge linkClk) disable iff (sys_rst)
    busActive && $past(busActive) |-> reference_clock_output != $past(reference_clock_output);
  endproperty
  a_refToggle: assert property (p_refToggle) else $error("refclock did not toggle");
  property p_latchLen;
    @(posedge linkClk) disable iff (sys_rst)
    $rose(addrLatch) |-> addrLatch ##1 addrLatch ##[1:3] !addrLatch;
  endproperty
  a_latchLen: assert property (p_latchLen) else $error("latch phase length wrong");
  property p_startLatch;
    @(posedge linkClk) disable iff (sys_rst) $rose(busActive) |-> addrLatch;
  endproperty
  a_startLatch: assert property (p_startLatch) else $error("cycle began without latch");
  property p_oneStrobe;
    @(posedge linkClk) disable iff (sys_rst) !(!rdStrobeN && !wrStrobeN);
  endproperty
  a_oneStrobe: assert property (p_oneStrobe) else $error("both strobes low");
  property p_strobeInCycle;
    @(posedge linkClk) disable iff (sys_rst)
    (!rdStrobeN || !wrStrobeN) |-> busActive && !addrLatch;
  endproperty
  a_strobeInCycle: assert property (p_strobeInCycle) else $error("strobe outside cmd phase");
  property p_strobeMin;
    @(posedge linkClk) disable iff (sys_rst) $fell(rdStrobeN) |-> !rdStrobeN [*2];
  endproperty
  a_strobeMin: assert property (p_strobeMin) else $error("read strobe too short");
  property p_cycleEnds;
    @(posedge linkClk) disable iff (sys_rst) $rose(busActive) |-> ##[3:200] !busActive;
  endproperty
  a_cycleEnds: assert property (p_cycleEnds) else $error("cycle never ended");
  // ----------------------------------------------------------------------
  // register bus side
  // ----------------------------------------------------------------------
  property p_readWait;
    @(posedge clk) disable iff (sys_rst) $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_readWait: assert property (p_readWait) else $error("read wait count wrong");
  property p_cfgWrite;
    @(posedge clk) disable iff (sys_rst) avs_write && avs_address != 4'h4 |-> !avs_waitrequest;
  endproperty
  a_cfgWrite: assert property (p_cfgWrite) else $error("config write stalled");
  c_latchExt: cover property (@(posedge linkClk) addrLatch [*4]);
  c_readCycle: cover property (@(posedge linkClk) $fell(rdStrobeN));
  c_writeCycle: cover property (@(posedge linkClk) $fell(wrStrobeN));
endmodule : ebc_bus_cycle_chk
bind ebc_bus_cycle ebc_bus_cycle_chk u_ebc_bus_cycle_chk (.clk(clk), .sys_rst(sys_rst),
  .linkClk(linkClk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .reference_clock_output(reference_clock_output),
  .addrLatch(addrLatch), .rdStrobeN(rdStrobeN), .wrStrobeN(wrStrobeN),
  .busActive(busActive));
`default_nettype wire

// ### ebc_ready_model.sv
// external glue that holds off the bus cycle through the ready pin
`timescale 1ns/1ps
`default_nettype none
module ebc_ready_model (
  // bus side
  input wire logic refClk,
  input wire logic rdN,
  input wire logic wrN,
  // waitstates to request per cycle
  input wire logic [7:0] waitCnt,
  output logic readyN
);
  logic [7:0] cnt;
  logic inCycle;
  initial
  begin
    readyN = 1'b1;
    cnt = 8'h00;
    inCycle = 1'b0;
  end
  // a strobe seen at a rising refclock edge arms the wait count
  always @(posedge refClk)
  begin
    #1;
    inCycle = !(rdN && wrN);
  end
  // moves just after the refclock falling edge, in step with it
  always @(negedge refClk)
  begin
    #1;
    if (inCycle && cnt < waitCnt)
    begin
      cnt = cnt + 8'h01;
      readyN = 1'b1; // stretch the running cycle
    end
    else if (inCycle)
    begin
      readyN = 1'b0;
    end
  end
  // withdrawn on the strobe trailing edge, before the next sample point
  always @(posedge rdN or posedge wrN)
  begin
    readyN <= 1'b1;
    cnt <= 8'h00;
  end
endmodule : ebc_ready_model
`default_nettype wire

// ### ebc_bus_cycle_tb_top.sv
// self-checking bench for the bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module ebc_bus_cycle_tb_top;
  import ebc_pkg::*;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic linkClk = 1'b0;
  logic [3:0] avAddr = 4'h0;
  logic avRd = 1'b0;
  logic avWr = 1'b0;
  logic [31:0] avWdata = 32'h0;
  logic [31:0] avRdata;
  logic avWait, readyN, refClk, aLatch, rdN, wrN, busAct, sawRd, sawWr;
  logic [7:0] waitCnt = 8'h00;
  int pinLen, miscompares = 0, checks = 0;
  logic [31:0] st;
  always #2 clk = ~clk;
  initial
  begin
    #13;
    forever #80 linkClk = ~linkClk;
  end
  ebc_bus_cycle u_ebc_bus_cycle (.clk(clk), .sys_rst(sysRst), .avs_address(avAddr),
    .avs_read(avRd), .avs_write(avWr), .avs_writedata(avWdata), .avs_byteenable(4'hf),
    .avs_readdata(avRdata), .avs_waitrequest(avWait), .linkClk(linkClk), .readyN(readyN),
    .reference_clock_output(refClk), .addrLatch(aLatch), .rdStrobeN(rdN), .wrStrobeN(wrN),
    .busActive(busAct));
  ebc_ready_model u_ebc_ready_model (.refClk(refClk), .rdN(rdN), .wrN(wrN),
    .waitCnt(waitCnt), .readyN(readyN));
  // pin-side cycle length in half units
  always @(negedge linkClk)
  begin
    if (busAct === 1'b1) pinLen++;
    if (rdN === 1'b0) sawRd = 1'b1;
    if (wrN === 1'b0) sawWr = 1'b1;
  end
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic busWr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avAddr <= a;
    avWdata <= d;
    avWr <= 1'b1;
    do @(negedge clk); while (avWait !== 1'b0);
    @(posedge clk);
    avWr <= 1'b0;
  endtask : busWr
  task automatic busRd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    avAddr <= a;
    avRd <= 1'b1;
    do @(negedge clk); while (avWait !== 1'b0);
    @(posedge clk);
    d = avRdata;
    avRd <= 1'b0;
  endtask : busRd
  task automatic runCycle(input logic [8:0] cfg, input logic wr, input logic [7:0] k,
    input int lo, input int hi);
    int n;
    waitCnt <= k;
    busWr(EBC_CFG_OFS, {23'h0, cfg});
    pinLen = 0;
    sawRd = 1'b0;
    sawWr = 1'b0;
    busWr(EBC_CMD_OFS, {30'h0, wr, 1'b1});
    n = 0;
    while (busAct !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    chk("start", {31'h0, busAct}, 32'h1);
    st = 32'h1;
    while (st[0] !== 1'b0) busRd(EBC_STAT_OFS, st);
    chk("statLen", {31'h0, st[15:8] >= lo && st[15:8] <= hi}, 32'h1);
    chk("pinLen", {31'h0, pinLen >= lo && pinLen <= hi}, 32'h1);
    chk("dir", {31'h0, st[2]}, {31'h0, wr});
    chk("strobe", {30'h0, sawWr, sawRd}, {30'h0, wr, !wr});
  endtask : runCycle
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic tRegs();
    busRd(EBC_CFG_OFS, st);
    chk("cfgReset", st, 32'h0);
    busWr(4'hc, 32'h1ff);
    busRd(4'hc, st);
    chk("unmapped", st, 32'h0);
    busWr(EBC_CFG_OFS, 32'hffff_ffff);
    busRd(EBC_CFG_OFS, st);
    chk("cfgRw", st, 32'h1ff);
    busWr(EBC_CMD_OFS, 32'h2);
    repeat (200) @(posedge clk);
    chk("noStart", {31'h0, busAct}, 32'h0);
  endtask : tRegs
  task automatic tTiming();
    logic [8:0] tab [8];
    int e;
    tab = '{9'h01f, 9'h03f, 9'h05f, 9'h07f, 9'h04f, 9'h000, 9'h017, 9'h06e};
    foreach (tab[i])
    begin
      e = 4 + 2 * tab[i][6] + 2 * tab[i][5] + 2 * (15 - tab[i][3:0]) + 2 * (1 - tab[i][4]);
      runCycle(tab[i], i[0], 8'h00, e, e);
    end
  endtask : tTiming
  task automatic tReady();
    runCycle(9'h09f, 1'b0, 8'h03, 10, 12);
    chk("rdyExt", {31'h0, st[1]}, 32'h1);
    runCycle(9'h09f, 1'b1, 8'h00, 4, 6);
    runCycle(9'h19f, 1'b0, 8'h00, 6, 12);
    chk("asyncExt", {31'h0, st[1]}, 32'h1);
  endtask : tReady
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  initial
  begin
    #150000;
    miscompares++;
    final_report();
  end
  initial
  begin
    // link side sees reset through a synchroniser, so hold it over several link periods
    repeat (20) @(posedge clk);
    repeat (5) @(posedge linkClk);
    @(posedge clk);
    sysRst <= 1'b0;
    repeat (4) @(posedge linkClk);
    tRegs();
    tTiming();
    tReady();
    final_report();
  end
endmodule : ebc_bus_cycle_tb_top
`default_nettype wire
